// ---- verilog/acs_sequencer.sv ----
/*
 Conversion sequencer: registers, power-up, calibration, group
 scheduling with preemption and the sequence modes.
 Assumes an analog front end that holds afe_data_i stable at conversion end.
*/
`timescale 1ns/1ps
module acs_sequencer import acs_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [5:0] ord_tmr_i,
	input wire logic ext_line11_i,
	input wire logic tmr1_trgout_i,
	input wire logic [5:0] pre_tmr_i,
	input wire logic ext_line15_i,
	input wire logic tmr1_ch4_i,
	input wire logic tmr1_ch1_i,
	input wire logic [11:0] afe_data_i,
	output logic afe_power_o,
	output logic afe_sensor_ref_o,
	output logic afe_convert_o,
	output logic [4:0] afe_channel_o,
	output logic afe_cal_o,
	output logic afe_cal_load_o,
	output logic [11:0] afe_cal_value_o,
	output logic ordinary_dma_o,
	output logic ordinary_end_irq_o,
	output logic preempted_end_irq_o
);
	typedef struct packed {
		acs_state_e st;
		logic [31:0] rdata;
		logic [15:0] ctrl1;
		logic [17:0] ctrl2;
		logic [1:0] div;
		logic [23:0] spt1;
		logic [29:0] spt2;
		logic [23:0] oseq1;
		logic [29:0] oseq2;
		logic [29:0] oseq3;
		logic [21:0] pseq;
		logic [4:0] sts;
		logic [11:0] ord_res;
		logic [3:0][11:0] pre_res;
		logic [11:0] d1;
		logic [11:0] d2;
		logic [7:0] cnt;
		logic busy;
		logic grp;
		logic [4:0] ch;
		logic ord_act;
		logic pre_act;
		logic ord_pend;
		logic pre_pend;
		logic [3:0] ord_pos;
		logic [3:0] ord_last;
		logic [3:0] ord_part;
		logic [1:0] pre_pos;
		logic [1:0] pre_last;
		logic [1:0] pre_part;
		logic dma;
		logic cal_load;
	} acs_core_s;
	acs_core_s q;
	acs_core_s n;
	logic tick;
	logic otrig;
	logic ptrig;
	logic pwr_retrig;
	logic [7:0] pres_off;
	logic [4:0] psum;
	logic [1:0] pfirst;
	logic [3:0] olen;

	// Channel number held in a five-bit slot of a flattened sequence
	function automatic logic [4:0] slot_ch(input logic [79:0] flat, input logic [3:0] idx);
		slot_ch = flat[idx * 5 +: 5];
	endfunction

	// Whole converter periods for a channel's sample code
	function automatic logic [7:0] conv_len(input logic [53:0] flat, input logic [4:0] ch);
		logic [2:0] code;
		code = flat[ch * 3 +: 3];
		conv_len = CONV_CYC[code];
	endfunction

	acs_clk_div u_div (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.run_i(q.ctrl2[C2_PWR]),
		.div_i(q.div),
		.tick_o(tick)
	);

	acs_trig_sel u_otrig (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.tmr_i(ord_tmr_i),
		.pin_i(ext_line11_i),
		.alt_i(tmr1_trgout_i),
		.fix_i(tmr1_trgout_i),
		.soft_i(q.ctrl2[C2_OSW]),
		.sel_i(q.ctrl2[C2_OSEL +: 4]),
		.mux_i(q.ctrl2[C2_OMUX]),
		.en_i(q.ctrl2[C2_OTE]),
		.trig_o(otrig)
	);

	acs_trig_sel u_ptrig (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.tmr_i(pre_tmr_i),
		.pin_i(ext_line15_i),
		.alt_i(tmr1_ch4_i),
		.fix_i(tmr1_ch1_i),
		.soft_i(q.ctrl2[C2_PSW]),
		.sel_i(q.ctrl2[C2_PSEL +: 4]),
		.mux_i(q.ctrl2[C2_PMUX]),
		.en_i(q.ctrl2[C2_PTE]),
		.trig_o(ptrig)
	);

	assign pres_off = addr_i - ADR_PRES1;
	assign olen = q.oseq1[SEQ_LEN +: 4];
	assign pfirst = 2'd3 - q.pseq[SEQ_LEN +: 2];
	assign psum = {1'b0, q.ord_part} + {2'b00, q.ctrl1[C1_PCNT +: 3]};

	always_comb begin
		n = q;
		n.dma = 1'b0;
		n.cal_load = 1'b0;
		// Soft trigger strobes meet the selector written with them
		n.ctrl2[C2_OSW] = 1'b0;
		n.ctrl2[C2_PSW] = 1'b0;
		n.rdata = 32'h0;
		n.d1 = afe_data_i;
		n.d2 = q.d1;
		pwr_retrig = 1'b0;
		// Register reads
		if (rd_i) begin
			if (addr_i == ADR_STS) begin
				n.rdata = {27'h0, q.sts};
			end else if (addr_i == ADR_CTRL1) begin
				n.rdata = {16'h0, q.ctrl1};
			end else if (addr_i == ADR_CTRL2) begin
				n.rdata = {14'h0, q.ctrl2 & 18'h3FF3F};
			end else if (addr_i == ADR_CDIV) begin
				n.rdata = {30'h0, q.div};
			end else if (addr_i == ADR_SPT1) begin
				n.rdata = {8'h0, q.spt1};
			end else if (addr_i == ADR_SPT2) begin
				n.rdata = {2'h0, q.spt2};
			end else if (addr_i == ADR_OSEQ1) begin
				n.rdata = {8'h0, q.oseq1};
			end else if (addr_i == ADR_OSEQ2) begin
				n.rdata = {2'h0, q.oseq2};
			end else if (addr_i == ADR_OSEQ3) begin
				n.rdata = {2'h0, q.oseq3};
			end else if (addr_i == ADR_PSEQ) begin
				n.rdata = {10'h0, q.pseq};
			end else if (addr_i >= ADR_PRES1 && addr_i <= ADR_PRES4 && addr_i[1:0] == 2'b00) begin
				n.rdata = {20'h0, q.pre_res[pres_off[3:2]]};
			end else if (addr_i == ADR_ORES) begin
				n.rdata = {20'h0, q.ord_res};
				n.sts[S_OEND] = 1'b0;
			end
		end
		// Register writes
		if (wr_i) begin
			if (addr_i == ADR_STS) begin
				n.sts[4:1] = q.sts[4:1] & wdata_i[4:1];
			end else if (addr_i == ADR_CTRL1) begin
				n.ctrl1 = wdata_i[15:0];
			end else if (addr_i == ADR_CTRL2) begin
				n.ctrl2 = wdata_i[17:0];
				n.ctrl2[C2_CAL] = q.ctrl2[C2_CAL] | wdata_i[C2_CAL];
				pwr_retrig = wdata_i[C2_PWR] & q.ctrl2[C2_PWR] & q.sts[S_RDY];
			end else if (addr_i == ADR_CDIV) begin
				n.div = wdata_i[1:0];
			end else if (addr_i == ADR_SPT1) begin
				n.spt1 = wdata_i[23:0];
			end else if (addr_i == ADR_SPT2) begin
				n.spt2 = wdata_i[29:0];
			end else if (addr_i == ADR_OSEQ1) begin
				n.oseq1 = wdata_i[23:0];
			end else if (addr_i == ADR_OSEQ2) begin
				n.oseq2 = wdata_i[29:0];
			end else if (addr_i == ADR_OSEQ3) begin
				n.oseq3 = wdata_i[29:0];
			end else if (addr_i == ADR_PSEQ) begin
				n.pseq = wdata_i[21:0];
			end
		end
		case (q.st)
			ST_OFF: begin
				if (n.ctrl2[C2_PWR]) begin
					n.st = ST_WAKE;
					n.cnt = 8'h0;
				end
			end
			ST_WAKE: begin
				if (tick) begin
					if (q.cnt == WAKE_CYC - 8'd1) begin
						n.sts[S_RDY] = 1'b1;
						n.st = ST_RUN;
					end else begin
						n.cnt = q.cnt + 8'd1;
					end
				end
			end
			ST_CAL: begin
				if (tick) begin
					if (q.cnt == CAL_CYC - 8'd1) begin
						n.ctrl2[C2_CAL] = 1'b0;
						n.ord_res = q.d2;
						n.cal_load = 1'b1;
						n.st = ST_RUN;
					end else begin
						n.cnt = q.cnt + 8'd1;
					end
				end
			end
			ST_RUN: begin
				if (q.ctrl2[C2_CAL] && !q.busy && !q.ord_act && !q.pre_act) begin
					n.st = ST_CAL;
					n.cnt = 8'h0;
				end
			end
			default: n.st = ST_OFF;
		endcase
		// Trigger capture while powered and ready
		if (q.st == ST_RUN || q.st == ST_CAL) begin
			if ((otrig || pwr_retrig) && !q.ord_act) begin
				n.ord_pend = 1'b1;
			end
			if (ptrig && !q.pre_act) begin
				n.pre_pend = 1'b1;
			end
		end
		if (q.st == ST_RUN) begin
			// Conversion countdown and completion
			if (q.busy && tick) begin
				if (q.cnt == 8'd1) begin
					n.busy = 1'b0;
					if (q.grp) begin
						n.pre_res[q.pre_pos] = q.d2;
						if (q.pre_pos == q.pre_last) begin
							n.pre_act = 1'b0;
							n.sts[S_PEND] = 1'b1;
							n.sts[S_OEND] = 1'b1;
							n.pre_part = (q.pre_pos == 2'd3) ? pfirst : q.pre_pos + 2'd1;
						end else begin
							n.pre_pos = q.pre_pos + 2'd1;
						end
					end else begin
						n.ord_res = q.d2;
						n.dma = 1'b1;
						if (q.ord_pos == q.ord_last) begin
							n.ord_act = 1'b0;
							n.sts[S_OEND] = 1'b1;
							n.ord_part = (q.ord_last >= olen) ? 4'h0 : q.ord_last + 4'h1;
							if (q.ctrl1[C1_AUTO]) begin
								n.pre_pend = 1'b1;
							end
							if (q.ctrl2[C2_REP]) begin
								n.ord_pend = 1'b1;
							end
						end else begin
							n.ord_pos = q.ord_pos + 4'h1;
						end
					end
				end else begin
					n.cnt = q.cnt - 8'd1;
				end
			end else if (!q.busy && (q.pre_act || q.ord_act) && tick) begin
				n.busy = 1'b1;
				n.grp = q.pre_act;
				n.ch = q.pre_act ? slot_ch({60'h0, q.pseq[19:0]}, {2'b00, q.pre_pos}) :
					slot_ch({q.oseq1[19:0], q.oseq2, q.oseq3}, q.ord_pos);
				n.cnt = conv_len({q.spt1, q.spt2}, n.ch);
				if (n.ch > CH_LAST) begin
					n.busy = 1'b0;
					n.ch = q.ch;
				end
			end
			// Group starts: preempted first, ordinary only while preempted is idle
			if (q.pre_pend && !q.pre_act) begin
				n.pre_pend = 1'b0;
				n.pre_act = 1'b1;
				n.sts[S_PSTA] = 1'b1;
				if (q.ctrl1[C1_PPART]) begin
					n.pre_pos = (q.pre_part < pfirst) ? pfirst : q.pre_part;
					n.pre_last = n.pre_pos;
				end else if (q.ctrl1[C1_SEQ]) begin
					n.pre_pos = pfirst;
					n.pre_last = 2'd3;
				end else begin
					n.pre_pos = 2'd3;
					n.pre_last = 2'd3;
				end
			end else if (q.ord_pend && !q.ord_act && !q.pre_act) begin
				n.ord_pend = 1'b0;
				n.ord_act = 1'b1;
				n.sts[S_OSTA] = 1'b1;
				if (q.ctrl1[C1_OPART]) begin
					n.ord_pos = (q.ord_part > olen) ? 4'h0 : q.ord_part;
					n.ord_last = (psum > {1'b0, olen}) ? olen : psum[3:0];
					if (q.ord_part > olen) begin
						n.ord_last = (q.ctrl1[C1_PCNT +: 3] > olen[2:0]) ? olen : {1'b0, q.ctrl1[C1_PCNT +: 3]};
					end
				end else if (q.ctrl1[C1_SEQ]) begin
					n.ord_pos = 4'h0;
					n.ord_last = olen;
				end else begin
					n.ord_pos = 4'h0;
					n.ord_last = 4'h0;
				end
			end
			// Preempted group aborts a running ordinary conversion, which restarts from the same slot later
			if (n.pre_act && n.busy && !n.grp) begin
				n.busy = 1'b0;
			end
		end
		// Power removal stops and resets the sequencer
		if (!n.ctrl2[C2_PWR]) begin
			n.st = ST_OFF;
			n.sts[S_RDY] = 1'b0;
			n.ctrl2[C2_CAL] = 1'b0;
			n.busy = 1'b0;
			n.ord_act = 1'b0;
			n.pre_act = 1'b0;
			n.ord_pend = 1'b0;
			n.pre_pend = 1'b0;
			n.ord_part = 4'h0;
			n.pre_part = 2'd0;
			n.dma = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q <= '0;
			q.st <= ST_OFF;
		end else begin
			q <= n;
		end
	end

	assign rdata_o = q.rdata;
	assign afe_power_o = q.ctrl2[C2_PWR];
	assign afe_sensor_ref_o = q.ctrl2[C2_SREF];
	assign afe_convert_o = q.busy;
	assign afe_channel_o = q.ch;
	assign afe_cal_o = (q.st == ST_CAL);
	assign afe_cal_load_o = q.cal_load;
	assign afe_cal_value_o = q.ord_res;
	assign ordinary_dma_o = q.dma;
	assign ordinary_end_irq_o = q.sts[S_OEND] & q.ctrl1[C1_OIE];
	assign preempted_end_irq_o = q.sts[S_PEND] & q.ctrl1[C1_PIE];
endmodule

// ---- verilog/acs_pkg.sv ----
/*
 Constants, register map and state codes of the converter sequencer.
 Assumes one 25 MHz clock and a plain word-wide register port.
*/
package acs_pkg;
	localparam logic [7:0] ADR_STS = 8'h00;
	localparam logic [7:0] ADR_CTRL1 = 8'h04;
	localparam logic [7:0] ADR_CTRL2 = 8'h08;
	localparam logic [7:0] ADR_SPT1 = 8'h0C;
	localparam logic [7:0] ADR_SPT2 = 8'h10;
	localparam logic [7:0] ADR_CDIV = 8'h14;
	localparam logic [7:0] ADR_OSEQ1 = 8'h2C;
	localparam logic [7:0] ADR_OSEQ2 = 8'h30;
	localparam logic [7:0] ADR_OSEQ3 = 8'h34;
	localparam logic [7:0] ADR_PSEQ = 8'h38;
	localparam logic [7:0] ADR_PRES1 = 8'h3C;
	localparam logic [7:0] ADR_PRES4 = 8'h48;
	localparam logic [7:0] ADR_ORES = 8'h4C;
	// Status bits
	localparam int S_RDY = 0;
	localparam int S_OEND = 1;
	localparam int S_PEND = 2;
	localparam int S_OSTA = 3;
	localparam int S_PSTA = 4;
	// Control 1 bits
	localparam int C1_OIE = 5;
	localparam int C1_PIE = 7;
	localparam int C1_SEQ = 8;
	localparam int C1_AUTO = 10;
	localparam int C1_OPART = 11;
	localparam int C1_PPART = 12;
	localparam int C1_PCNT = 13;
	// Control 2 bits
	localparam int C2_PWR = 0;
	localparam int C2_REP = 1;
	localparam int C2_CAL = 2;
	localparam int C2_SREF = 3;
	localparam int C2_OTE = 4;
	localparam int C2_PTE = 5;
	localparam int C2_OSW = 6;
	localparam int C2_PSW = 7;
	localparam int C2_OSEL = 8;
	localparam int C2_PSEL = 12;
	localparam int C2_OMUX = 16;
	localparam int C2_PMUX = 17;
	localparam int SEQ_LEN = 20;
	// Converter clock counts
	localparam logic [7:0] CAL_CYC = 8'd172;
	localparam logic [7:0] WAKE_CYC = 8'd16;
	// Whole conversion periods per sample code: sample time + 12.5
	localparam logic [7:0] CONV_CYC [8] = '{8'd14, 8'd20, 8'd26, 8'd41, 8'd54, 8'd68, 8'd84, 8'd252};
	localparam logic [3:0] SEL_SOFT = 4'h7;
	localparam logic [3:0] SEL_MUX = 4'h6;
	localparam logic [3:0] SEL_FIX = 4'hD;
	localparam logic [4:0] CH_LAST = 5'd17;
	typedef enum logic [3:0] {ST_OFF = 4'h1, ST_WAKE = 4'h2, ST_CAL = 4'h4, ST_RUN = 4'h8} acs_state_e;
endpackage

// ---- verilog/acs_clk_div.sv ----
/*
 Converter clock enable divider: one tick every 2*(div+1) clocks.
 Assumes run_i low holds the divider idle.
*/
`timescale 1ns/1ps
module acs_clk_div import acs_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire logic [1:0] div_i,
	output logic tick_o
);
	typedef struct packed {
		logic [2:0] cnt;
		logic tick;
	} acs_div_s;
	acs_div_s q;
	acs_div_s n;
	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (!run_i) begin
			n.cnt = 3'h0;
		end else if (q.cnt == {div_i, 1'b1}) begin
			n.cnt = 3'h0;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + 3'h1;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	assign tick_o = q.tick;
endmodule

// ---- verilog/acs_trig_sel.sv ----
/*
 Trigger source selector for one group: synchronises sources, detects
 rising edges and picks one by the selector code.
 Assumes sources are asynchronous levels; soft_i is a same-clock pulse.
*/
`timescale 1ns/1ps
module acs_trig_sel import acs_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [5:0] tmr_i,
	input wire logic pin_i,
	input wire logic alt_i,
	input wire logic fix_i,
	input wire logic soft_i,
	input wire logic [3:0] sel_i,
	input wire logic mux_i,
	input wire logic en_i,
	output logic trig_o
);
	typedef struct packed {
		logic [8:0] s1;
		logic [8:0] s2;
		logic [8:0] prev;
		logic trig;
	} acs_trig_s;
	acs_trig_s q;
	acs_trig_s n;
	logic [8:0] rise;
	logic ev;
	always_comb begin
		n = q;
		n.s1 = {fix_i, alt_i, pin_i, tmr_i};
		n.s2 = q.s1;
		n.prev = q.s2;
		rise = q.s2 & ~q.prev;
		ev = 1'b0;
		if (sel_i <= 4'h5) begin
			ev = rise[sel_i[2:0]];
		end else if (sel_i == SEL_MUX) begin
			ev = mux_i ? rise[7] : rise[6];
		end else if (sel_i == SEL_SOFT) begin
			ev = soft_i;
		end else if (sel_i == SEL_FIX) begin
			ev = rise[8];
		end
		n.trig = ev & en_i;
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	assign trig_o = q.trig;
endmodule

// ---- verif/acs_afe_model.sv ----
/*
 Analog front end model: returns a code built from the channel while converting.
 Assumes the sequencer's power, convert and calibrate levels.
*/
`timescale 1ns/1ps
module acs_afe_model #(
	parameter logic [11:0] CAL_VAL = 12'hA5C
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic power_i,
	input wire logic convert_i,
	input wire logic cal_i,
	input wire logic [4:0] channel_i,
	output logic [11:0] data_o
);
	logic [2:0] hold;
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			data_o <= 12'h000;
			hold <= 3'h0;
		end else if (power_i && cal_i) begin
			data_o <= CAL_VAL;
			hold <= 3'h4;
		end else if (power_i && convert_i) begin
			data_o <= {7'h4B, channel_i};
			hold <= 3'h4;
		end else if (hold != 3'h0) begin
			hold <= hold - 3'h1;
		end else begin
			data_o <= ~data_o;
		end
	end
endmodule

// ---- verif/acs_sequencer_checker.sv ----
/*
 Port checker of the converter sequencer.
 Assumes a converter tick of at least two clocks.
*/
`timescale 1ns/1ps
module acs_sequencer_checker (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic afe_power_o,
	input wire logic afe_convert_o,
	input wire logic [4:0] afe_channel_o,
	input wire logic afe_cal_o,
	input wire logic afe_cal_load_o,
	input wire logic ordinary_dma_o,
	input wire logic ordinary_end_irq_o
);
	logic [15:0] cal_cnt;
	logic [15:0] conv_cnt;
	logic [4:0] ch_q;
	logic cv_q;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// Length of the running calibration and of the last conversion
	always_ff @(posedge ref_clk_i) begin
		cal_cnt <= afe_cal_o ? cal_cnt + 16'h1 : 16'h0;
		cv_q <= afe_convert_o;
		ch_q <= afe_channel_o;
		if (afe_convert_o && (!cv_q || afe_channel_o != ch_q))
			conv_cnt <= 16'h0;
		else if (afe_convert_o)
			conv_cnt <= conv_cnt + 16'h1;
	end
	a_chan_in_range: assert property (afe_convert_o |-> afe_channel_o <= 5'd17)
		else $error("channel beyond last");
	a_conv_needs_pwr: assert property (afe_convert_o |-> afe_power_o || $past(afe_power_o))
		else $error("conversion while unpowered");
	a_wake_no_conv: assert property ($rose(afe_power_o) |-> !afe_convert_o [*8])
		else $error("conversion before ready");
	a_off_stops: assert property ($fell(afe_power_o) |-> ##[0:2] (!afe_convert_o && !afe_cal_o))
		else $error("power off left activity");
	a_cal_span: assert property ($fell(afe_cal_o) && afe_power_o |-> cal_cnt >= 16'd342)
		else $error("calibration too short");
	a_cal_quiet: assert property (afe_cal_load_o |-> !ordinary_dma_o && !$rose(ordinary_end_irq_o))
		else $error("calibration raised dma or end");
	a_cal_load_after: assert property (afe_cal_load_o |-> $past(afe_cal_o) || $past(afe_cal_o, 2)
		|| $past(afe_cal_o, 3))
		else $error("calibration load without calibration");
	a_conv_span: assert property (ordinary_dma_o |-> conv_cnt >= 16'd26)
		else $error("conversion too short");
endmodule

// ---- verif/acs_sequencer_tb.sv ----
/*
 Testbench of the converter sequencer.
 Assumes the front end model and the port checker.
*/
`timescale 1ns/1ps
module acs_sequencer_tb;
	import acs_pkg::*;
	localparam logic [11:0] CAL_VAL = 12'hA5C;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [16:0] src = 17'h0;
	logic [31:0] rdata;
	logic [11:0] afe_data;
	logic [11:0] cal_val;
	logic [4:0] chan;
	logic pwr, sref, conv, cal, cal_ld, dma, oirq, pirq;
	logic [4:0] seen[$];
	logic cv_q = 1'b0;
	logic oirq_q = 1'b0;
	logic [4:0] ch_q = 5'h0;
	int irq_at = 0;
	int dma_cnt = 0;
	int cyc = 0;
	int error_cnt = 0;
	int tests_run = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	acs_sequencer u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .ord_tmr_i(src[5:0]), .ext_line11_i(src[6]), .tmr1_trgout_i(src[7]),
		.pre_tmr_i(src[13:8]), .ext_line15_i(src[14]), .tmr1_ch4_i(src[15]), .tmr1_ch1_i(src[16]),
		.afe_data_i(afe_data), .afe_power_o(pwr), .afe_sensor_ref_o(sref), .afe_convert_o(conv),
		.afe_channel_o(chan), .afe_cal_o(cal), .afe_cal_load_o(cal_ld), .afe_cal_value_o(cal_val),
		.ordinary_dma_o(dma), .ordinary_end_irq_o(oirq), .preempted_end_irq_o(pirq));
	acs_afe_model #(.CAL_VAL(CAL_VAL)) u_afe (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .power_i(pwr),
		.convert_i(conv), .cal_i(cal), .channel_i(chan), .data_o(afe_data));
	// Records every channel that starts converting
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		cv_q <= conv;
		ch_q <= chan;
		oirq_q <= oirq;
		if (conv && (!cv_q || chan != ch_q))
			seen.push_back(chan);
		if (oirq && !oirq_q)
			irq_at <= seen.size();
		if (dma)
			dma_cnt <= dma_cnt + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		@(posedge ref_clk_i);
		v = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd_reg(a, v);
		chk(v, e);
	endtask
	task automatic settle;
		int idle;
		idle = 0;
		for (int i = 0; i < 4000 && idle < 40; i++) begin
			@(posedge ref_clk_i);
			idle = conv ? 0 : idle + 1;
		end
	endtask
	task automatic expect_seq(input int n, input logic [29:0] e);
		settle();
		chk(seen.size(), n);
		for (int i = 0; i < n && i < seen.size(); i++)
			chk(seen[i], e[5*i +: 5]);
		seen.delete();
	endtask
	task automatic pulse(input int idx);
		@(posedge ref_clk_i);
		src[idx] <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		src[idx] <= 1'b0;
	endtask
	task automatic cfg2(input logic [31:0] d);
		wr_reg(ADR_CTRL2, d);
		settle();
		seen.delete();
	endtask
	task automatic t_power_cal;
		int t0;
		logic [31:0] v;
		rd_chk(ADR_STS, 32'h0);
		rd_chk(8'h80, 32'h0);
		wr_reg(ADR_CDIV, 32'h0);
		t0 = cyc;
		wr_reg(ADR_CTRL2, 32'h5);
		rd_chk(ADR_STS, 32'h0);
		v = 32'h4;
		for (int i = 0; i < 300 && v[2]; i++)
			rd_reg(ADR_CTRL2, v);
		chk(v, 32'h1);
		chk(cyc - t0 >= 344, 1);
		rd_chk(ADR_ORES, {20'h0, CAL_VAL});
		chk(cal_val, {20'h0, CAL_VAL});
		rd_chk(ADR_STS, 32'h1);
		chk(dma_cnt, 0);
	endtask
	task automatic t_gate;
		wr_reg(ADR_CTRL2, 32'h1);
		expect_seq(1, 30'd2);
		rd_chk(ADR_ORES, {20'h0, 7'h4B, 5'd2});
		pulse(0);
		pulse(8);
		expect_seq(0, 30'd0);
	endtask
	task automatic t_soft;
		int n9;
		n9 = 0;
		wr_reg(ADR_CTRL2, 32'h000070B9);
		settle();
		foreach (seen[i])
			n9 += (seen[i] == 5'd9);
		chk(n9, 1);
		rd_chk(ADR_PRES4, {20'h0, 7'h4B, 5'd9});
		seen.delete();
		cfg2(32'h39);
		chk(sref, 1'b1);
	endtask
	task automatic t_preempt;
		pulse(0);
		repeat (100) @(posedge ref_clk_i);
		pulse(8);
		expect_seq(3, {5'd2, 5'd9, 5'd2});
		pulse(8);
		repeat (100) @(posedge ref_clk_i);
		pulse(0);
		expect_seq(2, {5'd2, 5'd9});
	endtask
	task automatic t_modes;
		wr_reg(ADR_CTRL1, 32'h1A0);
		wr_reg(ADR_STS, 32'h0);
		pulse(0);
		expect_seq(4, {5'd3, 5'd17, 5'd16, 5'd2});
		chk(irq_at, 4);
		chk(pirq, 1'b0);
		pulse(8);
		expect_seq(2, {5'd9, 5'd4});
		chk(pirq, 1'b1);
		wr_reg(ADR_CTRL1, 32'h500);
		pulse(0);
		expect_seq(6, {5'd9, 5'd4, 5'd3, 5'd17, 5'd16, 5'd2});
		wr_reg(ADR_CTRL1, 32'h2800);
		pulse(0);
		expect_seq(2, {5'd16, 5'd2});
		pulse(0);
		expect_seq(2, {5'd3, 5'd17});
		wr_reg(ADR_CTRL1, 32'h1000);
		pulse(8);
		expect_seq(1, 30'd4);
		pulse(8);
		expect_seq(1, 30'd9);
		wr_reg(ADR_CTRL1, 32'h0);
	endtask
	task automatic t_rep;
		wr_reg(ADR_CTRL2, 32'h3B);
		repeat (1100) @(posedge ref_clk_i);
		wr_reg(ADR_CTRL2, 32'h39);
		expect_seq(3, {5'd2, 5'd2, 5'd2});
	endtask
	task automatic hw(input logic g, input logic [3:0] s, input logic m, input int idx, input int n);
		cfg2(g ? {14'h0, m, 1'b0, s, 12'h039} : {14'h0, 1'b0, m, 4'h0, s, 8'h39});
		pulse(idx);
		settle();
		chk(seen.size(), n);
		seen.delete();
	endtask
	task automatic t_sel;
		for (int c = 0; c < 6; c++) begin
			hw(1'b0, c[3:0], 1'b0, c, 1);
			hw(1'b1, c[3:0], 1'b0, c + 8, 1);
		end
		hw(1'b0, 4'h6, 1'b0, 6, 1);
		hw(1'b0, 4'h6, 1'b1, 7, 1);
		hw(1'b0, 4'hD, 1'b0, 7, 1);
		hw(1'b0, 4'h6, 1'b0, 7, 0);
		hw(1'b0, 4'h8, 1'b0, 7, 0);
		hw(1'b1, 4'h6, 1'b0, 14, 1);
		hw(1'b1, 4'h6, 1'b1, 15, 1);
		hw(1'b1, 4'hD, 1'b0, 16, 1);
		hw(1'b1, 4'h9, 1'b0, 16, 0);
	endtask
	task automatic t_off;
		logic [31:0] v;
		pulse(0);
		repeat (100) @(posedge ref_clk_i);
		wr_reg(ADR_CTRL2, 32'h0);
		repeat (3) @(posedge ref_clk_i);
		chk(conv, 1'b0);
		rd_reg(ADR_STS, v);
		chk(v[0], 1'b0);
	endtask
	task automatic complete_run;
		$display("Checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		t_power_cal();
		wr_reg(ADR_SPT2, 32'h380001C0);
		wr_reg(ADR_OSEQ3, 32'h0001C602);
		wr_reg(ADR_OSEQ1, 32'h00300000);
		wr_reg(ADR_PSEQ, 32'h00149000);
		t_gate();
		t_soft();
		t_preempt();
		t_modes();
		t_rep();
		t_sel();
		t_off();
		complete_run();
	end
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		error_cnt++;
		complete_run();
	end
endmodule
bind acs_sequencer acs_sequencer_checker u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.afe_power_o(afe_power_o), .afe_convert_o(afe_convert_o), .afe_channel_o(afe_channel_o),
	.afe_cal_o(afe_cal_o), .afe_cal_load_o(afe_cal_load_o), .ordinary_dma_o(ordinary_dma_o),
	.ordinary_end_irq_o(ordinary_end_irq_o));
